/* bench/host_model.sv */
`timescale 1ns/1ns
module host_model (
	input wire logic clk_sys,
	input wire logic [3:0] data_out,
	output logic cs_n,
	output logic wr_n,
	output logic rd_n,
	output logic register_select_line,
	output logic [3:0] data_in
);
	// ------------------------------
	// Bus cycles
	// ------------------------------
	// Idle bus from time zero
	initial begin
		{cs_n, wr_n, rd_n, register_select_line, data_in} = 8'hf5;
	end
	task automatic acc(input logic sel, input logic rd, input logic [3:0] d,
		output logic [3:0] q);
		@(posedge clk_sys);
		#1;
		{cs_n, rd_n, wr_n, register_select_line, data_in} = {1'b0, !rd, rd, sel, d};
		repeat (5) @(posedge clk_sys);
		#1;
		// Read data settled two cycles ago, taken off the edge
		q = data_out;
		// Released data lines show the inverse, not the old value
		{cs_n, rd_n, wr_n, data_in} = {3'b111, ~d};
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic sel, input logic [3:0] d);
		logic [3:0] q;
		acc(sel, 1'b0, d, q);
	endtask
	task automatic rd(input logic sel, output logic [3:0] q);
		acc(sel, 1'b1, 4'h0, q);
	endtask
	task automatic init(output logic [3:0] q);
		rd(1'b1, q);
		wr(1'b1, 4'h0);
		wr(1'b1, 4'h0);
		wr(1'b1, 4'h8);
		wr(1'b1, 4'h0);
		rd(1'b1, q);
	endtask
endmodule // host_model

/* bench/tone_ctrl_checker.sv */
`timescale 1ns/1ns
module tone_ctrl_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [3:0] data_out,
	input wire logic data_oe,
	input wire logic [3:0] tx_digit,
	input wire logic tone_drive,
	input wire logic tone_output_enable,
	input wire logic single_tone,
	input wire logic column_tone,
	input wire logic receiver_power_down,
	input wire logic call_progress_select,
	input wire logic osc_power_down,
	input wire logic interrupt_or_progress_pin_o
);
	// ------------------------------
	// Port relations
	// ------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Repetition allows for one register stage
	AST_OSC_DOWN: assert property (
		(!tone_output_enable && receiver_power_down)[*3] |-> osc_power_down)
		else $error("oscillator left running");
	AST_OSC_UP: assert property (
		tone_output_enable[*3] |-> !osc_power_down) else $error("oscillator stopped");
	AST_TX_CLEAR: assert property (
		(!tone_output_enable)[*2] |-> tx_digit == 4'h0) else $error("tx digit kept");
	AST_TONE_GATED: assert property (
		(!tone_output_enable)[*2] |-> !tone_drive) else $error("tone while off");
	// Open drain: only ever pulls low
	AST_PIN_OPEN: assert property (
		interrupt_or_progress_pin_o == 1'b0) else $error("pin driven high");
	AST_OE_OFF: assert property (
		rd_n[*4] |-> !data_oe) else $error("bus driven without read");
	AST_OE_ON: assert property (
		(!cs_n && !rd_n)[*5] |-> data_oe) else $error("bus not driven on read");
	AST_DATA_HOLD: assert property (
		rd_n[*5] |-> $stable(data_out)) else $error("read data moved");
	AST_TX_HOLD: assert property (
		(wr_n && tone_output_enable)[*5] |-> $stable(tx_digit)) else $error("tx moved");
	AST_CTL_HOLD: assert property (
		wr_n[*5] |-> $stable({single_tone, column_tone, receiver_power_down,
		call_progress_select, tone_output_enable})) else $error("control moved");
	// Main scenarios
	cover property (!rd_n && data_oe);
	cover property ($rose(osc_power_down));
	cover property ($rose(tone_drive));
endmodule // tone_ctrl_checker
bind tone_transceiver_ctrl_status tone_ctrl_checker chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.cs_n(cs_n),
	.wr_n(wr_n),
	.rd_n(rd_n),
	.data_out(data_out),
	.data_oe(data_oe),
	.tx_digit(tx_digit),
	.tone_drive(tone_drive),
	.tone_output_enable(tone_output_enable),
	.single_tone(single_tone),
	.column_tone(column_tone),
	.receiver_power_down(receiver_power_down),
	.call_progress_select(call_progress_select),
	.osc_power_down(osc_power_down),
	.interrupt_or_progress_pin_o(interrupt_or_progress_pin_o)
);

/* bench/tone_transceiver_ctrl_status_tb.sv */
`timescale 1ns/1ns
module tone_transceiver_ctrl_status_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, wr_n, rd_n, register_select_line, data_oe, tone_drive, toe, single_tone;
	logic column_tone, rx_down, cp_sel, osc_down, pin_oe;
	logic rx_digit_valid = 1'b0, tone_absent = 1'b0, tone_present = 1'b0, sq = 1'b0;
	logic [3:0] data_in, data_out, tx_digit, q;
	logic [3:0] rx_digit = 4'h9;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	// Short burst: 100 cycles of tone, 100 of pause
	localparam logic [23:0] BURST_LEN = 24'h000064;
	// ------------------------------
	// Clock, parts, checks
	// ------------------------------
	always #4 clk_sys = ~clk_sys;
	host_model host (.clk_sys(clk_sys), .data_out(data_out), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .register_select_line(register_select_line), .data_in(data_in));
	tone_transceiver_ctrl_status #(.BURST_LEN(BURST_LEN)) dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.register_select_line(register_select_line),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.rx_digit_valid(rx_digit_valid), .rx_digit(rx_digit), .tone_absent(tone_absent),
		.tone_present(tone_present), .progress_square(sq), .tx_digit(tx_digit),
		.tone_drive(tone_drive), .tone_output_enable(toe), .single_tone(single_tone),
		.column_tone(column_tone), .receiver_power_down(rx_down),
		.call_progress_select(cp_sel), .osc_power_down(osc_down),
		.interrupt_or_progress_pin_o(), .interrupt_or_progress_pin_oe(pin_oe));
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Hang guard, well above the 820 or so cycles needed
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end
	// Main sequence
	initial begin
		w(3);
		rst_n = 1'b1;
		w(2);
		chk(osc_down, 1'b0);
		host.init(q);
		chk(q, 4'h0);
		host.wr(1'b1, 4'hd);
		host.wr(1'b1, 4'hc);
		chk({column_tone, single_tone, rx_down, toe}, 4'hd);
		host.wr(1'b0, 4'h7);
		chk(tx_digit, 4'h7);
		chk(tone_drive, 1'b1);
		host.rd(1'b1, q);
		chk(q, 4'h0);
		w(1);
		rx_digit_valid = 1'b1;
		w(6);
		chk(pin_oe, 1'b1);
		host.rd(1'b1, q);
		chk(q, 4'h5);
		chk(pin_oe, 1'b0);
		host.rd(1'b0, q);
		chk(q, 4'h9);
		host.rd(1'b1, q);
		chk(q, 4'h0);
		// Silence then tone again
		w(1);
		{rx_digit_valid, tone_absent} = 2'b01;
		w(6);
		host.rd(1'b1, q);
		chk(q, 4'h8);
		w(1);
		{tone_absent, tone_present} = 2'b01;
		w(6);
		host.rd(1'b1, q);
		chk(q, 4'h0);
		// First digit: tone, equal pause, then ready
		w(20);
		chk(tone_drive, 1'b0);
		w(80);
		chk(pin_oe, 1'b0);
		w(20);
		chk(pin_oe, 1'b1);
		host.rd(1'b1, q);
		chk(q, 4'h3);
		// Leave burst mode, then power everything down
		host.wr(1'b1, 4'h9);
		host.wr(1'b1, 4'h1);
		chk(tone_drive, 1'b1);
		host.rd(1'b1, q);
		chk(q, 4'h0);
		host.wr(1'b1, 4'h8);
		chk(tone_drive, 1'b0);
		chk(tx_digit, 4'h0);
		host.wr(1'b1, 4'h3);
		chk({osc_down, rx_down}, 2'h3);
		host.wr(1'b1, 4'h1);
		chk({toe, osc_down}, 2'h2);
		host.wr(1'b1, 4'h6);
		chk(cp_sel, 1'b1);
		// Square wave drives the pin in progress mode
		w(1);
		sq = 1'b1;
		w(4);
		chk(pin_oe, 1'b0);
		sq = 1'b0;
		w(4);
		chk(pin_oe, 1'b1);
		// Extended burst: tone and pause both doubled
		host.wr(1'b1, 4'hb);
		host.wr(1'b1, 4'h0);
		host.wr(1'b0, 4'h5);
		w(190);
		chk(tone_drive, 1'b1);
		w(10);
		chk(tone_drive, 1'b0);
		w(185);
		host.rd(1'b1, q);
		chk(q, 4'h0);
		host.rd(1'b1, q);
		chk(q, 4'h3);
		test_done();
	end
endmodule // tone_transceiver_ctrl_status_tb

/* rtl/burst_if.sv */
`timescale 1ns/1ns
interface burst_if;
	logic start;
	logic abort;
	logic extended;
	logic tone_on;
	logic done;
	logic busy;
	modport ctrl (output start, output abort, output extended,
		input tone_on, input done, input busy);
	modport timer (input start, input abort, input extended,
		output tone_on, output done, output busy);
endinterface

/* rtl/burst_timer.sv */
`timescale 1ns/1ns
module burst_timer #(
	parameter logic [23:0] BURST_LEN = 24'(tone_pkg::BURST_CYCLES)
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	burst_if.timer bus
);
	typedef enum logic [2:0] {
		IDLE = 3'b001,
		TONE = 3'b010,
		PAUSE = 3'b100
	} phase_e;

	phase_e phase_q, phase_d;
	logic [tone_pkg::COUNT_W-1:0] count_q, count_d;
	logic [tone_pkg::COUNT_W-1:0] limit;
	logic done_q, done_d;

	// ----------------------------------------
	// Tone then equal pause, doubled when extended
	// ----------------------------------------
	always_comb begin
		limit = bus.extended ? (BURST_LEN << 1) : BURST_LEN;
		phase_d = phase_q;
		count_d = count_q;
		done_d = 1'b0;
		unique case (phase_q)
			IDLE: begin
				if (bus.start) begin
					phase_d = TONE;
					count_d = '0;
				end
			end
			TONE: begin
				count_d = count_q + 1'b1;
				if (count_q == limit - 1'b1) begin
					phase_d = PAUSE;
					count_d = '0;
				end
			end
			PAUSE: begin
				count_d = count_q + 1'b1;
				if (count_q == limit - 1'b1) begin
					phase_d = IDLE;
					done_d = 1'b1;
				end
			end
		endcase
		// Abort beats everything, pause done never reported
		if (bus.abort) begin
			phase_d = IDLE;
			done_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			phase_q <= IDLE;
			count_q <= '0;
			done_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			count_q <= count_d;
			done_q <= done_d;
		end
	end

	assign bus.tone_on = (phase_q == TONE);
	assign bus.done = done_q;
	assign bus.busy = (phase_q != IDLE);
endmodule // burst_timer

/* rtl/tone_pkg.sv */
package tone_pkg;
	// ----------------------------------------
	// Register bit positions
	// ----------------------------------------
	localparam int unsigned CTL_FIRST_TONE_OUT = 0;
	localparam int unsigned CTL_FIRST_PROGRESS = 1;
	localparam int unsigned CTL_FIRST_IRQ_EN = 2;
	localparam int unsigned CTL_FIRST_STEER = 3;
	localparam int unsigned CTL_SECOND_BURST_OFF = 0;
	localparam int unsigned CTL_SECOND_RX_DOWN = 1;
	localparam int unsigned CTL_SECOND_SINGLE = 2;
	localparam int unsigned CTL_SECOND_COLUMN = 3;
	localparam int unsigned STAT_IRQ = 0;
	localparam int unsigned STAT_TX_EMPTY = 1;
	localparam int unsigned STAT_RX_FULL = 2;
	localparam int unsigned STAT_DELAYED_STEER = 3;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0] CTL_FIRST_RESET = 4'h0;
	// Burst disabled until software selects it
	localparam logic [3:0] CTL_SECOND_RESET = 4'h1;
	localparam logic [3:0] STATUS_RESET = 4'h0;

	// ----------------------------------------
	// Burst timing
	// ----------------------------------------
	localparam longint unsigned CLK_HZ = 125000000;
	localparam longint unsigned BURST_US = 50000;
	localparam longint unsigned BURST_CYCLES = (BURST_US * CLK_HZ) / 1000000;
	localparam int unsigned COUNT_W = 24;
endpackage

/* rtl/tone_transceiver_ctrl_status.sv */
`timescale 1ns/1ns
module tone_transceiver_ctrl_status #(
	// Tone and pause length in clock cycles each when not extended
	parameter logic [23:0] BURST_LEN = 24'(tone_pkg::BURST_CYCLES)
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic register_select_line,
	input wire logic [3:0] data_in,
	output logic [3:0] data_out,
	output logic data_oe,
	input wire logic rx_digit_valid,
	input wire logic [3:0] rx_digit,
	input wire logic tone_absent,
	input wire logic tone_present,
	input wire logic progress_square,
	output logic [3:0] tx_digit,
	output logic tone_drive,
	output logic tone_output_enable,
	output logic single_tone,
	output logic column_tone,
	output logic receiver_power_down,
	output logic call_progress_select,
	output logic osc_power_down,
	output logic interrupt_or_progress_pin_o,
	output logic interrupt_or_progress_pin_oe
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] s1_q, s2_q, s1_d, s2_d;
	logic [3:0] rxd1_q, rxd2_q, din1_q, din2_q;
	logic [3:0] rxd1_d, rxd2_d, din1_d, din2_d;
	logic rs1_q, rs2_q, rs1_d, rs2_d;
	logic [1:0] sel1_q, sel2_q, sel1_d, sel2_d;
	logic cs_s, wr_s, rd_s;

	// Pins are asynchronous; two stages before any use
	always_comb begin
		s1_d = {cs_n, wr_n, rd_n, rx_digit_valid, tone_absent};
		s2_d = s1_q;
		sel1_d = {tone_present, progress_square};
		sel2_d = sel1_q;
		rxd1_d = rx_digit;
		rxd2_d = rxd1_q;
		din1_d = data_in;
		din2_d = din1_q;
		rs1_d = register_select_line;
		rs2_d = rs1_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s1_q <= 5'h1c;
			s2_q <= 5'h1c;
			sel1_q <= 2'h0;
			sel2_q <= 2'h0;
			rxd1_q <= 4'h0;
			rxd2_q <= 4'h0;
			din1_q <= 4'h0;
			din2_q <= 4'h0;
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			sel1_q <= sel1_d;
			sel2_q <= sel2_d;
			rxd1_q <= rxd1_d;
			rxd2_q <= rxd2_d;
			din1_q <= din1_d;
			din2_q <= din2_d;
			rs1_q <= rs1_d;
			rs2_q <= rs2_d;
		end
	end

	assign cs_s = ~s2_q[4];
	assign wr_s = ~s2_q[3];
	assign rd_s = ~s2_q[2];

	// ----------------------------------------
	// Access decode: one access per select
	// ----------------------------------------
	logic done_q, done_d;
	logic wr_go, rd_go, rxv_prev_q, rxv_prev_d, rxv_rise;

	// Only the first strobe after chip select counts
	always_comb begin
		wr_go = cs_s && wr_s && !done_q;
		rd_go = cs_s && rd_s && !done_q;
		done_d = cs_s ? (done_q | wr_s | rd_s) : 1'b0;
		rxv_prev_d = s2_q[1];
		rxv_rise = s2_q[1] && !rxv_prev_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			rxv_prev_q <= 1'b0;
		end else begin
			done_q <= done_d;
			rxv_prev_q <= rxv_prev_d;
		end
	end

	// ----------------------------------------
	// Control, data and status registers
	// ----------------------------------------
	logic [3:0] first_q, first_d, second_q, second_d, status_q, status_d;
	logic [3:0] txd_q, txd_d, rxd_q, rxd_d, dout_q, dout_d;
	logic steer_q, steer_d, doe_q, doe_d, burst_mode;
	burst_if bt();

	burst_timer #(
		.BURST_LEN(BURST_LEN)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.bus(bt)
	);

	assign burst_mode = !second_q[tone_pkg::CTL_SECOND_BURST_OFF];

	always_comb begin
		first_d = first_q;
		second_d = second_q;
		steer_d = steer_q;
		txd_d = txd_q;
		rxd_d = rxd_q;
		status_d = status_q;
		dout_d = dout_q;
		doe_d = cs_s && rd_s;
		if (wr_go && rs2_q) begin
			if (steer_q) begin
				second_d = din2_q;
				steer_d = 1'b0;
			end else begin
				first_d = din2_q;
				steer_d = din2_q[tone_pkg::CTL_FIRST_STEER];
			end
		end
		if (wr_go && !rs2_q)
			txd_d = din2_q;
		if (rd_go) begin
			dout_d = rs2_q ? status_q : rxd_q;
			if (rs2_q) begin
				status_d[tone_pkg::STAT_IRQ] = 1'b0;
				status_d[tone_pkg::STAT_TX_EMPTY] = 1'b0;
				status_d[tone_pkg::STAT_RX_FULL] = 1'b0;
			end
		end
		if (rxv_rise) begin
			rxd_d = rxd2_q;
			status_d[tone_pkg::STAT_RX_FULL] = 1'b1;
		end
		if (bt.done)
			status_d[tone_pkg::STAT_TX_EMPTY] = 1'b1;
		if (!burst_mode)
			status_d[tone_pkg::STAT_TX_EMPTY] = 1'b0;
		if (s2_q[0])
			status_d[tone_pkg::STAT_DELAYED_STEER] = 1'b1;
		else if (sel2_q[1])
			status_d[tone_pkg::STAT_DELAYED_STEER] = 1'b0;
		if (status_d[tone_pkg::STAT_TX_EMPTY] || status_d[tone_pkg::STAT_RX_FULL])
			status_d[tone_pkg::STAT_IRQ] = 1'b1;
		if (!first_d[tone_pkg::CTL_FIRST_TONE_OUT])
			txd_d = 4'h0;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			first_q <= tone_pkg::CTL_FIRST_RESET;
			second_q <= tone_pkg::CTL_SECOND_RESET;
			status_q <= tone_pkg::STATUS_RESET;
			steer_q <= 1'b0;
			txd_q <= 4'h0;
			rxd_q <= 4'h0;
			dout_q <= 4'h0;
			doe_q <= 1'b0;
		end else begin
			first_q <= first_d;
			second_q <= second_d;
			status_q <= status_d;
			steer_q <= steer_d;
			txd_q <= txd_d;
			rxd_q <= rxd_d;
			dout_q <= dout_d;
			doe_q <= doe_d;
		end
	end

	// ----------------------------------------
	// Burst timer hookup
	// ----------------------------------------
	// digit write starts burst
	// counters on system clock
	// A digit written mid-burst does not restart the timer
	assign bt.start = wr_go && !rs2_q && burst_mode && !bt.busy
		&& first_q[tone_pkg::CTL_FIRST_TONE_OUT];
	assign bt.abort = !burst_mode || !first_q[tone_pkg::CTL_FIRST_TONE_OUT];
	assign bt.extended = first_q[tone_pkg::CTL_FIRST_PROGRESS];

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	logic [11:0] outs_q, outs_d;
	logic irq_low;

	always_comb begin
		if (first_q[tone_pkg::CTL_FIRST_PROGRESS])
			irq_low = first_q[tone_pkg::CTL_FIRST_IRQ_EN] && !sel2_q[0];
		else
			irq_low = first_q[tone_pkg::CTL_FIRST_IRQ_EN] && status_q[tone_pkg::STAT_IRQ];
		outs_d[3:0] = txd_q;
		outs_d[4] = burst_mode ? bt.tone_on : first_q[tone_pkg::CTL_FIRST_TONE_OUT];
		outs_d[5] = first_q[tone_pkg::CTL_FIRST_TONE_OUT];
		outs_d[6] = second_q[tone_pkg::CTL_SECOND_SINGLE];
		outs_d[7] = second_q[tone_pkg::CTL_SECOND_SINGLE] && second_q[tone_pkg::CTL_SECOND_COLUMN];
		outs_d[8] = second_q[tone_pkg::CTL_SECOND_RX_DOWN];
		outs_d[9] = first_q[tone_pkg::CTL_FIRST_PROGRESS];
		outs_d[10] = !first_q[tone_pkg::CTL_FIRST_TONE_OUT] && second_q[tone_pkg::CTL_SECOND_RX_DOWN];
		outs_d[11] = irq_low;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			outs_q <= 12'h400;
		else
			outs_q <= outs_d;
	end

	assign data_out = dout_q;
	assign data_oe = doe_q;
	assign tx_digit = outs_q[3:0];
	assign tone_drive = outs_q[4];
	assign tone_output_enable = outs_q[5];
	assign single_tone = outs_q[6];
	assign column_tone = outs_q[7];
	assign receiver_power_down = outs_q[8];
	assign call_progress_select = outs_q[9];
	assign osc_power_down = outs_q[10];
	// Open drain: only ever pulls low
	assign interrupt_or_progress_pin_o = 1'b0;
	assign interrupt_or_progress_pin_oe = outs_q[11];
endmodule // tone_transceiver_ctrl_status
